// ===== rtl/adc_cfg_regs.vh
// Register offsets, field positions and reset values of the configuration slice.
// Included by the register bank and the pattern generator; definitions only.
`ifndef ADC_CFG_REGS_VH
`define ADC_CFG_REGS_VH

`define ADDR_INPUT_CFG      8'h11
`define ADDR_FUSE_LOAD      8'h13
`define ADDR_PAT_LOW        8'h14
`define ADDR_PAT_MID        8'h15
`define ADDR_PAT_SEL        8'h16

`define BIT_SE_A            5
`define BIT_SE_B            4
`define BIT_DELAY_LINE_POWERDOWN         2
`define BIT_AUTO_ZERO_ENABLE           0
`define BIT_FUSE_LD         0

`define INPUT_CFG_MASK      8'h35
`define FUSE_LOAD_MASK      8'h01
`define PAT_HI_LSB          0
`define PAT_HI_MSB          1
`define PAT_SEL_A_LSB       2
`define PAT_SEL_A_MSB       4
`define PAT_SEL_B_LSB       5
`define PAT_SEL_B_MSB       7

`define RST_INPUT_CFG_SLOW  8'h01
`define RST_INPUT_CFG_FAST  8'h00
`define RST_ZERO            8'h00

`define PAT_MODE_NORMAL     3'h0
`define PAT_MODE_RAMP       3'h2
`define PAT_MODE_CONST      3'h3

`define PAT_WIDTH           18

`endif

// ===== rtl/test_pattern_gen.v
// One channel's test pattern generator, ahead of the output bit mapper.
// Assumes a sample strobe on the sampling clock; converter data MSB-aligned.
`default_nettype none
`include "adc_cfg_regs.vh"

module test_pattern_gen #(
    parameter DATA_WIDTH = 14
) (
    input  wire                  core_clk_i,
    input  wire                  rst_i,
    input  wire                  sample_valid_i,
    input  wire [2:0]            mode_i,
    input  wire [`PAT_WIDTH-1:0] custom_pattern_i,
    input  wire [DATA_WIDTH-1:0] adc_data_i,
    output reg  [DATA_WIDTH-1:0] data_o
);
    reg  [`PAT_WIDTH-1:0] ramp_r;
    wire [`PAT_WIDTH-1:0] ramp_nxt;

    // 18-bit accumulator wraps naturally at full scale
    assign ramp_nxt = ramp_r + custom_pattern_i;

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            ramp_r <= {`PAT_WIDTH{1'b0}};
            data_o <= {DATA_WIDTH{1'b0}};
        end else if (sample_valid_i) begin
            if (mode_i == `PAT_MODE_RAMP) begin
                ramp_r <= ramp_nxt;
            end else begin
                ramp_r <= {`PAT_WIDTH{1'b0}};
            end
            // Top bits of the 18-bit word give native resolution, MSB first
            case (mode_i)
                `PAT_MODE_RAMP: begin
                    data_o <= ramp_r[`PAT_WIDTH-1 -: DATA_WIDTH];
                end
                `PAT_MODE_CONST: begin
                    data_o <= custom_pattern_i[`PAT_WIDTH-1 -: DATA_WIDTH];
                end
                default: begin
                    // Unused codes fall back to live data
                    data_o <= adc_data_i;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== rtl/adc_config_test_pattern_regs.v
// Configuration register slice: input type, sampling delay line, auto-zero,
// fuse-load strobe and per-channel test patterns. Register writes arrive
// already decoded from the serial control port, synchronous to core_clk_i.
`default_nettype none
`include "adc_cfg_regs.vh"

// Behaviour
// - Bit 5 picks channel A single-ended, bit 4 channel B.
// - Delay line on: sample at quarter period; off: follows clock duty.
// - Bit 0 enables auto-zero; reset value depends on speed grade.
// - Fuse-load bit loads output bit mapping for selected interface.
// - Fuse load returns earlier register writes to defaults.
// - 18-bit custom pattern over three registers, output MSB-aligned.
// - Channel A select: 000 normal, 010 ramp, 011 constant.
// - Channel B select, same encoding, independent of A.
// - Patterns inserted before bit mapper, native resolution, MSB aligned.
module adc_config_test_pattern_regs #(
    parameter       DATA_WIDTH = 14,
    parameter [0:0] FAST_GRADE = 1'b0
) (
    input  wire                  core_clk_i,
    input  wire                  rst_i,
    input  wire                  reg_wr_i,
    input  wire                  reg_rd_i,
    input  wire [7:0]            reg_addr_i,
    input  wire [7:0]            reg_wdata_i,
    output reg  [7:0]            reg_rdata_o,
    input  wire                  sample_valid_i,
    input  wire [DATA_WIDTH-1:0] chan_a_adc_data_i,
    input  wire [DATA_WIDTH-1:0] chan_b_adc_data_i,
    output reg  [DATA_WIDTH-1:0] chan_a_data_o,
    output reg  [DATA_WIDTH-1:0] chan_b_data_o,
    output wire                  chan_a_single_ended_o,
    output wire                  chan_b_single_ended_o,
    output wire                  delay_line_powerdown_o,
    output wire                  sample_at_quarter_o,
    output wire                  auto_zero_enable_o,
    output reg                   mapping_load_o
);
    localparam [7:0] INPUT_CFG_RST = FAST_GRADE ? `RST_INPUT_CFG_FAST
                                                : `RST_INPUT_CFG_SLOW;

    reg  [7:0] input_and_sampling_config_r;
    reg  [7:0] fuse_load_strobe_r;
    reg  [7:0] custom_pattern_low_r;
    reg  [7:0] custom_pattern_mid_r;
    reg  [7:0] test_pattern_select_r;
    wire       fuse_rise;
    wire [`PAT_WIDTH-1:0] custom_pattern_value;
    wire [2:0] chan_a_pattern_select;
    wire [2:0] chan_b_pattern_select;
    wire [DATA_WIDTH-1:0] chan_a_pat;
    wire [DATA_WIDTH-1:0] chan_b_pat;

    // Load fires on the 0-to-1 write of the strobe bit
    assign fuse_rise = reg_wr_i && (reg_addr_i == `ADDR_FUSE_LOAD)
                       && reg_wdata_i[`BIT_FUSE_LD]
                       && !fuse_load_strobe_r[`BIT_FUSE_LD];

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            input_and_sampling_config_r <= INPUT_CFG_RST;
            fuse_load_strobe_r          <= `RST_ZERO;
            custom_pattern_low_r        <= `RST_ZERO;
            custom_pattern_mid_r        <= `RST_ZERO;
            test_pattern_select_r       <= `RST_ZERO;
            mapping_load_o              <= 1'b0;
        end else begin
            mapping_load_o <= fuse_rise;
            if (fuse_rise) begin
                // Load wipes prior configuration; the strobe itself is kept
                input_and_sampling_config_r <= INPUT_CFG_RST;
                custom_pattern_low_r        <= `RST_ZERO;
                custom_pattern_mid_r        <= `RST_ZERO;
                test_pattern_select_r       <= `RST_ZERO;
                fuse_load_strobe_r          <= reg_wdata_i & `FUSE_LOAD_MASK;
            end else if (reg_wr_i) begin
                case (reg_addr_i)
                    `ADDR_INPUT_CFG: begin
                        // Reserved bits held at zero
                        input_and_sampling_config_r <= reg_wdata_i & `INPUT_CFG_MASK;
                    end
                    `ADDR_FUSE_LOAD: begin
                        fuse_load_strobe_r <= reg_wdata_i & `FUSE_LOAD_MASK;
                    end
                    `ADDR_PAT_LOW: begin
                        custom_pattern_low_r <= reg_wdata_i;
                    end
                    `ADDR_PAT_MID: begin
                        custom_pattern_mid_r <= reg_wdata_i;
                    end
                    `ADDR_PAT_SEL: begin
                        test_pattern_select_r <= reg_wdata_i;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= `RST_ZERO;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `ADDR_INPUT_CFG: reg_rdata_o <= input_and_sampling_config_r;
                `ADDR_FUSE_LOAD: reg_rdata_o <= fuse_load_strobe_r;
                `ADDR_PAT_LOW:   reg_rdata_o <= custom_pattern_low_r;
                `ADDR_PAT_MID:   reg_rdata_o <= custom_pattern_mid_r;
                `ADDR_PAT_SEL:   reg_rdata_o <= test_pattern_select_r;
                default:         reg_rdata_o <= `RST_ZERO;
            endcase
        end
    end

    assign chan_a_single_ended_o  = input_and_sampling_config_r[`BIT_SE_A];
    assign chan_b_single_ended_o  = input_and_sampling_config_r[`BIT_SE_B];
    assign delay_line_powerdown_o = input_and_sampling_config_r[`BIT_DELAY_LINE_POWERDOWN];
    // Quarter-period sampling only while the delay line runs
    assign sample_at_quarter_o    = !input_and_sampling_config_r[`BIT_DELAY_LINE_POWERDOWN];
    assign auto_zero_enable_o     = input_and_sampling_config_r[`BIT_AUTO_ZERO_ENABLE];

    assign custom_pattern_value = {test_pattern_select_r[`PAT_HI_MSB:`PAT_HI_LSB],
                                   custom_pattern_mid_r, custom_pattern_low_r};
    assign chan_a_pattern_select = test_pattern_select_r[`PAT_SEL_A_MSB:`PAT_SEL_A_LSB];
    assign chan_b_pattern_select = test_pattern_select_r[`PAT_SEL_B_MSB:`PAT_SEL_B_LSB];

    // Channel A pattern path
    test_pattern_gen #(
        .DATA_WIDTH       (DATA_WIDTH)
    ) u_pat_a (
        .core_clk_i       (core_clk_i),
        .rst_i            (rst_i),
        .sample_valid_i   (sample_valid_i),
        .mode_i           (chan_a_pattern_select),
        .custom_pattern_i (custom_pattern_value),
        .adc_data_i       (chan_a_adc_data_i),
        .data_o           (chan_a_pat)
    );

    // Channel B runs independently of A
    test_pattern_gen #(
        .DATA_WIDTH       (DATA_WIDTH)
    ) u_pat_b (
        .core_clk_i       (core_clk_i),
        .rst_i            (rst_i),
        .sample_valid_i   (sample_valid_i),
        .mode_i           (chan_b_pattern_select),
        .custom_pattern_i (custom_pattern_value),
        .adc_data_i       (chan_b_adc_data_i),
        .data_o           (chan_b_pat)
    );

    // Mapper follows downstream; patterns enter it at native width
    always @* begin
        chan_a_data_o = chan_a_pat;
        chan_b_data_o = chan_b_pat;
    end
endmodule
`default_nettype wire

// ===== test/adc_cfg_checker_assertions.sv
// Port-level checks for the configuration slice.
// Assumes it is bound to adc_config_test_pattern_regs, one clock domain.
`default_nettype none
module adc_cfg_checker #(
    parameter       DATA_WIDTH = 14,
    parameter [0:0] FAST_GRADE = 1'b0
) (
    input wire logic                  core_clk_i, rst_i, reg_wr_i, sample_valid_i,
    input wire logic [7:0]            reg_addr_i, reg_wdata_i,
    input wire logic [DATA_WIDTH-1:0] chan_a_data_o, chan_b_data_o,
    input wire logic                  chan_a_single_ended_o, chan_b_single_ended_o,
    input wire logic                  delay_line_powerdown_o, sample_at_quarter_o,
    input wire logic                  auto_zero_enable_o, mapping_load_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_cfg_wr;
        reg_wr_i && reg_addr_i == 8'h11;
    endsequence
    sequence s_fuse_wr;
        reg_wr_i && reg_addr_i == 8'h13 && reg_wdata_i[0];
    endsequence
    property p_se;
        s_cfg_wr |=> chan_a_single_ended_o == $past(reg_wdata_i[5])
            && chan_b_single_ended_o == $past(reg_wdata_i[4]);
    endproperty
    property p_dll;
        s_cfg_wr |=> delay_line_powerdown_o == $past(reg_wdata_i[2]);
    endproperty
    property p_az;
        s_cfg_wr |=> auto_zero_enable_o == $past(reg_wdata_i[0]);
    endproperty
    property p_quarter;
        sample_at_quarter_o != delay_line_powerdown_o;
    endproperty
    property p_fuse_cause;
        mapping_load_o |-> $past(reg_wr_i && reg_addr_i == 8'h13 && reg_wdata_i[0]);
    endproperty
    property p_fuse_pulse;
        s_fuse_wr ##1 mapping_load_o |=> !mapping_load_o;
    endproperty
    property p_fuse_clear;
        mapping_load_o |-> !chan_a_single_ended_o && !chan_b_single_ended_o
            && !delay_line_powerdown_o && auto_zero_enable_o == !FAST_GRADE;
    endproperty
    property p_hold;
        !sample_valid_i |=> $stable(chan_a_data_o) && $stable(chan_b_data_o);
    endproperty
    a_se: assert property (p_se) else $error("input type bit wrong");
    a_dll: assert property (p_dll) else $error("delay line bit wrong");
    a_az: assert property (p_az) else $error("auto-zero bit wrong");
    a_quarter: assert property (p_quarter) else $error("sampling instant wrong");
    a_fuse_cause: assert property (p_fuse_cause) else $error("load without write");
    a_fuse_pulse: assert property (p_fuse_pulse) else $error("load pulse too long");
    a_fuse_clear: assert property (p_fuse_clear) else $error("load kept settings");
    a_hold: assert property (p_hold) else $error("data moved without sample");
endmodule
bind adc_config_test_pattern_regs adc_cfg_checker #(.DATA_WIDTH(DATA_WIDTH),
    .FAST_GRADE(FAST_GRADE)) chk_i (.core_clk_i, .rst_i, .reg_wr_i, .sample_valid_i,
    .reg_addr_i, .reg_wdata_i, .chan_a_data_o, .chan_b_data_o, .chan_a_single_ended_o,
    .chan_b_single_ended_o, .delay_line_powerdown_o, .sample_at_quarter_o,
    .auto_zero_enable_o, .mapping_load_o);
`default_nettype wire

// ===== test/host_model.sv
// Host on the register port: one write or read per task call.
// Assumes strobes are sampled on the rising edge of core_clk_i.
`default_nettype none
module host_model (
    input  wire logic       core_clk_i,
    input  wire logic [7:0] rdata_i,
    output var  logic       wr_o,
    output var  logic       rd_o,
    output var  logic [7:0] addr_o,
    output var  logic [7:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_o, rd_o, addr_o, wdata_o} = 18'h0;
    // Calls go out in caller order; fuse pulse first is the caller's duty
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge core_clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge core_clk_i);
        rd_o <= 1'b0;
        @(posedge core_clk_i);
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench: register table, config outputs, patterns, fuse load.
// Assumes host_model drives the register port; 200 MHz clock.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk_i = 1'b0, rst_i = 1'b1, sample_valid_i = 1'b0;
    logic        reg_wr_i, reg_rd_i, se_a, se_b, dll, quarter, az, map_ld;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, rd;
    logic [13:0] adc_a = 14'h1234, adc_b = 14'h0ABC, out_a, out_b;
    logic [17:0] acc;
    int          n_mismatch = 0, total_checks = 0, cyc = 0;
    // Rows: write flag, address, write data, expected read-back
    logic [24:0] rows [11] = '{25'h0_11_00_01, 25'h0_13_00_00, 25'h0_14_00_00,
        25'h0_15_00_00, 25'h0_16_00_00, 25'h1_11_FF_35, 25'h1_14_A5_A5,
        25'h1_15_3C_3C, 25'h1_16_FF_FF, 25'h1_12_77_00, 25'h1_13_FE_00};
    always #2.5 core_clk_i = ~core_clk_i;
    host_model h (.core_clk_i(core_clk_i), .rdata_i(reg_rdata_o), .wr_o(reg_wr_i),
        .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
    adc_config_test_pattern_regs uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .sample_valid_i(sample_valid_i), .chan_a_adc_data_i(adc_a),
        .chan_b_adc_data_i(adc_b), .chan_a_data_o(out_a), .chan_b_data_o(out_b),
        .chan_a_single_ended_o(se_a), .chan_b_single_ended_o(se_b),
        .delay_line_powerdown_o(dll), .sample_at_quarter_o(quarter),
        .auto_zero_enable_o(az), .mapping_load_o(map_ld));
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic smp;
        @(posedge core_clk_i) sample_valid_i <= 1'b1;
        @(posedge core_clk_i) sample_valid_i <= 1'b0;
        #1;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            finish_test;
        end
    end
    initial begin
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i][24]) h.wr(rows[i][23:16], rows[i][15:8]);
            h.rd(rows[i][23:16], rd);
            chk(rd, rows[i][7:0]);
        end
        chk({se_a, se_b, dll, quarter, az}, 5'b11101);
        h.wr(8'h11, 8'h00);
        @(posedge core_clk_i) #1;
        chk({se_a, se_b, dll, quarter, az}, 5'b00010);
        h.wr(8'h14, 8'hCD);
        h.wr(8'h15, 8'hAB);
        h.wr(8'h16, 8'h0E);
        smp;
        chk(out_a, 14'h2ABC);
        chk(out_b, adc_b);
        // Step near full scale so the ramp wraps within three samples
        h.wr(8'h14, 8'hF0);
        h.wr(8'h15, 8'hFF);
        h.wr(8'h16, 8'h47);
        acc = 18'h0;
        repeat (3) begin
            smp;
            chk(out_b, acc[17:4]);
            chk(out_a, adc_a);
            acc = acc + 18'h3FFF0;
        end
        // Swap roles: A ramps, B holds the constant
        h.wr(8'h14, 8'h00);
        h.wr(8'h15, 8'h01);
        h.wr(8'h16, 8'h68);
        smp;
        chk(out_a, 14'h0000);
        chk(out_b, 14'h0010);
        smp;
        chk(out_a, 14'h0010);
        chk(out_b, 14'h0010);
        h.wr(8'h13, 8'h01);
        #1;
        chk(map_ld, 1'b1);
        h.rd(8'h11, rd);
        chk(rd, 8'h01);
        h.rd(8'h16, rd);
        chk(rd, 8'h00);
        h.rd(8'h13, rd);
        chk(rd, 8'h01);
        h.wr(8'h13, 8'h00);
        // Mid-run reset returns every register to its default
        @(posedge core_clk_i) rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        #1;
        chk(out_a, 14'h0000);
        chk({se_a, se_b, dll, quarter, az}, 5'b00011);
        h.rd(8'h13, rd);
        chk(rd, 8'h00);
        finish_test;
    end
endmodule
`default_nettype wire
